// ===== hw/mmbr_regs.sv
// Mask, offset, test and command-space register bank of the hardware monitor
`timescale 1ns/1ps
`default_nettype none
module mmbr_regs (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_valid,
  output logic [1:0] cmd_kind_r,
  output logic [7:0] cmd_base_r,
  output logic [5:0] cmd_len_r,
  output logic cmd_reserved_r,
  input wire logic [7:0] input_err_raw,
  input wire logic [3:0] fan_err_raw,
  input wire logic [2:0] tv_err_raw,
  input wire logic [5:0] misc_err_raw,
  output logic [7:0] input_err_r,
  output logic [3:0] fan_err_r,
  output logic [2:0] tv_err_r,
  output logic [5:0] misc_err_r,
  input wire logic [7:0] zone1a_raw,
  input wire logic [7:0] zone2a_raw,
  input wire logic temp_valid,
  output logic [7:0] zone1a_temp_r,
  output logic [7:0] zone2a_temp_r,
  output logic xor_tree_mode_on,
  output logic cpu1_diode_a_transistor_on,
  output logic cpu1_diode_b_transistor_on,
  output logic cpu2_diode_a_transistor_on,
  output logic cpu2_diode_b_transistor_on
);
  logic [7:0] xor_test_r, scratch_r, diode_mode_r, sleep_ctrl_r;
  logic [7:0] s1_input_mask_r, s1_fan_error_mask_r, s3_input_mask_r, s3_fan_error_mask_r;
  logic [7:0] s3_tv_mask_r, s45_input_mask_r, s45_tv_mask_r, input_fault_mask_r;
  logic [7:0] misc_mask_r, zone1a_offset_r, zone2a_offset_r;
  logic [7:0] rdata_nxt;
  logic hit_nxt;
  logic [1:0] dec_kind;
  logic [7:0] dec_base;
  logic [5:0] dec_len;
  logic dec_reserved;

  function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] target);
    wr_hit = we && (a == target);
  endfunction

  // Write strobes per register
  wire w_xor = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_XOR_TEST);
  wire w_scr = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_SCRATCH);
  wire w_dio = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_DIODE_MODE);
  wire w_slp = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_SLEEP_CTRL);
  wire w_s1i = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_S1_INPUT_MASK);
  wire w_s1f = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_S1_FAN_ERROR_MASK);
  wire w_s3i = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_S3_INPUT_MASK);
  wire w_s3f = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_S3_FAN_ERROR_MASK);
  wire w_s3t = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_S3_TV_MASK);
  wire w_s4i = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_S45_INPUT_MASK);
  wire w_s4t = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_S45_TV_MASK);
  wire w_gim = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_INPUT_FAULT_MASK);
  wire w_msc = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_MISC_MASK);
  wire w_z1 = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_ZONE1A_OFFSET);
  wire w_z2 = wr_hit(reg_wr, reg_addr, mmbr_pkg::ADDR_ZONE2A_OFFSET);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      xor_test_r <= mmbr_pkg::RST_XOR_TEST;
      scratch_r <= mmbr_pkg::RST_SCRATCH;
      diode_mode_r <= mmbr_pkg::RST_DIODE_MODE;
      sleep_ctrl_r <= mmbr_pkg::RST_SLEEP_CTRL;
      s1_input_mask_r <= mmbr_pkg::RST_INPUT_MASK;
      s1_fan_error_mask_r <= mmbr_pkg::RST_FAN_MASK;
      s3_input_mask_r <= mmbr_pkg::RST_INPUT_MASK;
      s3_fan_error_mask_r <= mmbr_pkg::RST_FAN_MASK;
      s3_tv_mask_r <= mmbr_pkg::RST_TV_MASK;
      s45_input_mask_r <= mmbr_pkg::RST_INPUT_MASK;
      s45_tv_mask_r <= mmbr_pkg::RST_TV_MASK;
      input_fault_mask_r <= mmbr_pkg::RST_INPUT_MASK;
      misc_mask_r <= mmbr_pkg::RST_MISC_MASK;
      zone1a_offset_r <= mmbr_pkg::RST_OFFSET;
      zone2a_offset_r <= mmbr_pkg::RST_OFFSET;
    end else begin
      if (w_xor) xor_test_r <= reg_wdata & mmbr_pkg::XOR_WR_MASK;
      if (w_scr) scratch_r <= reg_wdata;
      if (w_dio) diode_mode_r <= reg_wdata & mmbr_pkg::DIODE_WR_MASK;
      if (w_slp) sleep_ctrl_r <= reg_wdata;
      if (w_s1i) s1_input_mask_r <= reg_wdata;
      if (w_s1f) s1_fan_error_mask_r <= reg_wdata;
      if (w_s3i) s3_input_mask_r <= reg_wdata;
      if (w_s3f) s3_fan_error_mask_r <= reg_wdata;
      if (w_s3t) s3_tv_mask_r <= reg_wdata;
      if (w_s4i) s45_input_mask_r <= reg_wdata;
      if (w_s4t) s45_tv_mask_r <= reg_wdata;
      if (w_gim) input_fault_mask_r <= reg_wdata;
      if (w_msc) misc_mask_r <= reg_wdata;
      if (w_z1) zone1a_offset_r <= reg_wdata;
      if (w_z2) zone2a_offset_r <= reg_wdata;
    end
  end

  // Read mux; unmapped addresses read zero and report no hit
  always_comb begin
    rdata_nxt = 8'h00;
    hit_nxt = 1'b1;
    unique case (reg_addr)
      mmbr_pkg::ADDR_XOR_TEST: rdata_nxt = xor_test_r;
      mmbr_pkg::ADDR_SCRATCH: rdata_nxt = scratch_r;
      mmbr_pkg::ADDR_DIODE_MODE: rdata_nxt = diode_mode_r;
      mmbr_pkg::ADDR_SLEEP_CTRL: rdata_nxt = sleep_ctrl_r;
      mmbr_pkg::ADDR_S1_INPUT_MASK: rdata_nxt = s1_input_mask_r;
      mmbr_pkg::ADDR_S1_FAN_ERROR_MASK: rdata_nxt = s1_fan_error_mask_r;
      mmbr_pkg::ADDR_S3_INPUT_MASK: rdata_nxt = s3_input_mask_r;
      mmbr_pkg::ADDR_S3_FAN_ERROR_MASK: rdata_nxt = s3_fan_error_mask_r;
      mmbr_pkg::ADDR_S3_TV_MASK: rdata_nxt = s3_tv_mask_r;
      mmbr_pkg::ADDR_S45_INPUT_MASK: rdata_nxt = s45_input_mask_r;
      mmbr_pkg::ADDR_S45_TV_MASK: rdata_nxt = s45_tv_mask_r;
      mmbr_pkg::ADDR_INPUT_FAULT_MASK: rdata_nxt = input_fault_mask_r;
      mmbr_pkg::ADDR_MISC_MASK: rdata_nxt = misc_mask_r;
      mmbr_pkg::ADDR_ZONE1A_OFFSET: rdata_nxt = zone1a_offset_r;
      mmbr_pkg::ADDR_ZONE2A_OFFSET: rdata_nxt = zone2a_offset_r;
      default: hit_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
      reg_hit <= hit_nxt;
    end
  end

  // Register-mapped control outputs, straight from flops
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      xor_tree_mode_on <= 1'b0;
      cpu1_diode_a_transistor_on <= 1'b0;
      cpu1_diode_b_transistor_on <= 1'b0;
      cpu2_diode_a_transistor_on <= 1'b0;
      cpu2_diode_b_transistor_on <= 1'b0;
    end else begin
      xor_tree_mode_on <= xor_test_r[mmbr_pkg::XOR_EN_BIT];
      cpu1_diode_a_transistor_on <= diode_mode_r[0];
      cpu1_diode_b_transistor_on <= diode_mode_r[1];
      cpu2_diode_a_transistor_on <= diode_mode_r[2];
      cpu2_diode_b_transistor_on <= diode_mode_r[3];
    end
  end

  // Sleep-state masking; unknown state codes get only the always-on masks
  wire in_s1 = sleep_ctrl_r == mmbr_pkg::MMBR_S1;
  wire in_s3 = sleep_ctrl_r == mmbr_pkg::MMBR_S3;
  wire in_s45 = sleep_ctrl_r == mmbr_pkg::MMBR_S45;
  wire [7:0] input_mask_eff = input_fault_mask_r | ({8{in_s1}} & s1_input_mask_r)
                              | ({8{in_s3}} & s3_input_mask_r) | ({8{in_s45}} & s45_input_mask_r);
  wire [3:0] fan_mask_eff = ({4{in_s1}} & s1_fan_error_mask_r[3:0]) | ({4{in_s3}} & s3_fan_error_mask_r[3:0]);
  wire [2:0] tv_mask_eff = ({3{in_s3}} & s3_tv_mask_r[2:0]) | ({3{in_s45}} & s45_tv_mask_r[2:0]);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      input_err_r <= 8'h00;
      fan_err_r <= 4'h0;
      tv_err_r <= 3'h0;
      misc_err_r <= 6'h00;
    end else begin
      input_err_r <= input_err_raw & ~input_mask_eff;
      fan_err_r <= fan_err_raw & ~fan_mask_eff;
      tv_err_r <= tv_err_raw & ~tv_mask_eff;
      misc_err_r <= misc_err_raw & ~misc_mask_r[5:0];
    end
  end

  // Offset is two's complement; the sum wraps in 8 bits
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      zone1a_temp_r <= 8'h00;
      zone2a_temp_r <= 8'h00;
    end else if (temp_valid) begin
      zone1a_temp_r <= 8'(zone1a_raw + zone1a_offset_r);
      zone2a_temp_r <= 8'(zone2a_raw + zone2a_offset_r);
    end
  end

  mmbr_cmd_decode u_dec (
    .cmd_code(cmd_code),
    .cmd_kind(dec_kind),
    .blk_base(dec_base),
    .blk_len(dec_len),
    .cmd_reserved(dec_reserved)
  );

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cmd_kind_r <= mmbr_pkg::MMBR_CMD_REG;
      cmd_base_r <= 8'h00;
      cmd_len_r <= 6'h00;
      cmd_reserved_r <= 1'b0;
    end else if (cmd_valid) begin
      cmd_kind_r <= dec_kind;
      cmd_base_r <= dec_base;
      cmd_len_r <= dec_len;
      cmd_reserved_r <= dec_reserved;
    end
  end

  a_sleep_reset: assert property (@(posedge sys_clk) $rose(reset_n) |-> sleep_ctrl_r == 8'h03)
    else $error("sleep control reset value wrong");
  a_s1_fan_error_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_s1 && s1_fan_error_mask_r[0] && fan_err_raw[0]) |=> !fan_err_r[0])
    else $error("S1 fan error not masked");
  a_s3_tv_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_s3 && s3_tv_mask_r[1] && tv_err_raw[1]) |=> !tv_err_r[1])
    else $error("S3 temp/volt error not masked");
  a_awake_tv_pass: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (sleep_ctrl_r == 8'h00 && tv_err_raw == 3'h7) |=> tv_err_r == 3'h7)
    else $error("awake temp/volt error masked");
  a_input_fault_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (input_fault_mask_r[2] && input_err_raw[2]) |=> !input_err_r[2])
    else $error("input fault not masked");
  a_misc_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!misc_mask_r[0] && misc_err_raw[0]) |=> misc_err_r[0])
    else $error("unmasked misc error lost");
  a_zone1a_offset: assert property (@(posedge sys_clk) disable iff (!reset_n)
    temp_valid |=> zone1a_temp_r == 8'($past(zone1a_raw) + $past(zone1a_offset_r)))
    else $error("zone 1a offset not applied");
  a_zone2a_offset: assert property (@(posedge sys_clk) disable iff (!reset_n)
    temp_valid |=> zone2a_temp_r == 8'($past(zone2a_raw) + $past(zone2a_offset_r)))
    else $error("zone 2a offset not applied");
  a_block_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == 8'hF0) |=> cmd_kind_r == mmbr_pkg::MMBR_CMD_BWRITE)
    else $error("block write not decoded");
  a_block_call: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == 8'hF1) |=> cmd_kind_r == mmbr_pkg::MMBR_CMD_BCALL)
    else $error("block call not decoded");
  a_fixed_f5: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == 8'hF5) |=> cmd_base_r == 8'h56 && cmd_len_r == 6'h10)
    else $error("fixed block F5h range wrong");
  a_fixed_f9: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == 8'hF9) |=> cmd_base_r == 8'h90 && cmd_len_r == 6'h20)
    else $error("fixed block F9h range wrong");
  a_fixed_fd: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == 8'hFD) |=> cmd_base_r == 8'hE5 && cmd_len_r == 6'h09)
    else $error("fixed block FDh range wrong");
  a_xor_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (w_xor && reg_wdata[0]) |=> ##1 xor_tree_mode_on)
    else $error("xor test mode not entered");
  a_xor_reserved: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == 8'h00) |=> reg_rdata[7:1] == 7'h00)
    else $error("xor reserved bits not zero");
  a_scratch_echo: assert property (@(posedge sys_clk) disable iff (!reset_n)
    w_scr ##1 !reg_wr ##1 (reg_rd && reg_addr == 8'h01 && !reg_wr) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("scratch readback mismatch");
  a_diode_bits: assert property (@(posedge sys_clk) disable iff (!reset_n)
    w_dio |=> ##1 {cpu2_diode_b_transistor_on, cpu2_diode_a_transistor_on, cpu1_diode_b_transistor_on,
                   cpu1_diode_a_transistor_on} == $past(reg_wdata[3:0], 2))
    else $error("diode mode bits wrong");
  a_diode_reserved: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == 8'h05) |=> reg_rdata[7:4] == 4'h0)
    else $error("diode reserved bits not zero");
  a_sleep_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    w_slp |=> sleep_ctrl_r == $past(reg_wdata))
    else $error("sleep control write lost");
  // Per-state masks act only while that state is reported
  a_s1_input_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_s1 && s1_input_mask_r[3] && input_err_raw[3]) |=> !input_err_r[3])
    else $error("S1 input error not masked");
  a_s3_input_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_s3 && s3_input_mask_r[5] && input_err_raw[5]) |=> !input_err_r[5])
    else $error("S3 input error not masked");
  a_s3_fan_error_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_s3 && s3_fan_error_mask_r[2] && fan_err_raw[2]) |=> !fan_err_r[2])
    else $error("S3 fan error not masked");
  a_s45_input_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_s45 && s45_input_mask_r[7] && input_err_raw[7]) |=> !input_err_r[7])
    else $error("S4/5 input error not masked");
  a_s45_tv_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_s45 && s45_tv_mask_r[0] && tv_err_raw[0]) |=> !tv_err_r[0])
    else $error("S4/5 temp/volt error not masked");
  // Fan errors have no S4/5 mask, so they must pass there
  a_s45_fan_pass: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_s45 && fan_err_raw[1]) |=> fan_err_r[1])
    else $error("S4/5 fan error lost");
  a_misc_masked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (misc_mask_r[5] && misc_err_raw[5]) |=> !misc_err_r[5])
    else $error("misc error not masked");
  a_reserved_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == 8'hFE) |=> cmd_reserved_r && cmd_len_r == 6'h00)
    else $error("reserved code not flagged");
  a_fixed_f2: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == 8'hF2) |=> cmd_base_r == 8'h40 && cmd_len_r == 6'h08)
    else $error("fixed block F2h range wrong");
  a_fixed_f6: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == 8'hF6) |=> cmd_base_r == 8'h67 && cmd_len_r == 6'h04)
    else $error("fixed block F6h range wrong");
  a_fixed_fa: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code == 8'hFA) |=> cmd_base_r == 8'hB4 && cmd_len_r == 6'h08)
    else $error("fixed block FAh range wrong");
  a_plain_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmd_valid && cmd_code < 8'hF0) |=> cmd_kind_r == mmbr_pkg::MMBR_CMD_REG && cmd_len_r == 6'h00)
    else $error("plain code decoded as block");
  a_scratch_isolated: assert property (@(posedge sys_clk) disable iff (!reset_n)
    w_scr |=> $stable(sleep_ctrl_r) && $stable(misc_mask_r) && $stable(xor_test_r))
    else $error("scratch write disturbed a setting");
  a_xor_exit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (w_xor && !reg_wdata[0]) |=> ##1 !xor_tree_mode_on)
    else $error("xor test mode not left");
  // Read data must stand until the next read strobe
  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !reg_rd |=> $stable(reg_rdata) && $stable(reg_hit))
    else $error("read data changed without a read");

  c_sleep_s3: cover property (@(posedge sys_clk) disable iff (!reset_n) w_slp && reg_wdata == 8'h03);
  c_block_call: cover property (@(posedge sys_clk) disable iff (!reset_n) cmd_valid && cmd_code == 8'hF1);
  c_fixed_last: cover property (@(posedge sys_clk) disable iff (!reset_n) cmd_valid && cmd_code == 8'hFD);
  c_xor_on: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(xor_tree_mode_on));
  c_s45_masking: cover property (@(posedge sys_clk) disable iff (!reset_n) in_s45 && |tv_err_raw);
endmodule
`default_nettype wire

// ===== hw/mmbr_pkg.sv
// Constants for the monitor mask and block command register bank
package mmbr_pkg;
  localparam logic [7:0] ADDR_XOR_TEST = 8'h00;
  localparam logic [7:0] ADDR_SCRATCH = 8'h01;
  localparam logic [7:0] ADDR_DIODE_MODE = 8'h05;
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'hE4;
  localparam logic [7:0] ADDR_S1_INPUT_MASK = 8'hE5;
  localparam logic [7:0] ADDR_S1_FAN_ERROR_MASK = 8'hE6;
  localparam logic [7:0] ADDR_S3_INPUT_MASK = 8'hE7;
  localparam logic [7:0] ADDR_S3_FAN_ERROR_MASK = 8'hE8;
  localparam logic [7:0] ADDR_S3_TV_MASK = 8'hE9;
  localparam logic [7:0] ADDR_S45_INPUT_MASK = 8'hEA;
  localparam logic [7:0] ADDR_S45_TV_MASK = 8'hEB;
  localparam logic [7:0] ADDR_INPUT_FAULT_MASK = 8'hEC;
  localparam logic [7:0] ADDR_MISC_MASK = 8'hED;
  localparam logic [7:0] ADDR_ZONE1A_OFFSET = 8'hEE;
  localparam logic [7:0] ADDR_ZONE2A_OFFSET = 8'hEF;

  localparam logic [7:0] RST_XOR_TEST = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_DIODE_MODE = 8'h00;
  localparam logic [7:0] RST_SLEEP_CTRL = 8'h03;
  localparam logic [7:0] RST_INPUT_MASK = 8'hFF;
  localparam logic [7:0] RST_FAN_MASK = 8'h0F;
  localparam logic [7:0] RST_TV_MASK = 8'h07;
  localparam logic [7:0] RST_MISC_MASK = 8'h3F;
  localparam logic [7:0] RST_OFFSET = 8'h00;

  localparam int XOR_EN_BIT = 0;
  localparam logic [7:0] XOR_WR_MASK = 8'h01;
  localparam logic [7:0] DIODE_WR_MASK = 8'h0F;

  localparam logic [7:0] CMD_BLOCK_WRITE = 8'hF0;
  localparam logic [7:0] CMD_BLOCK_CALL = 8'hF1;
  localparam logic [7:0] CMD_FIXED_FIRST = 8'hF2;
  localparam logic [7:0] CMD_FIXED_LAST = 8'hFD;
  localparam logic [7:0] CMD_RESERVED_FIRST = 8'hFE;

  // Sleep state encodings as reported by the host
  typedef enum logic [7:0] {
    MMBR_S0 = 8'h00,
    MMBR_S1 = 8'h01,
    MMBR_S3 = 8'h03,
    MMBR_S45 = 8'h04
  } mmbr_sleep_e;

  typedef enum logic [1:0] {
    MMBR_CMD_REG = 2'h0,
    MMBR_CMD_BWRITE = 2'h1,
    MMBR_CMD_BCALL = 2'h2,
    MMBR_CMD_FIXED = 2'h3
  } mmbr_cmd_e;
endpackage

// ===== hw/mmbr_cmd_decode.sv
// Command code decoder: block commands and fixed register ranges
`timescale 1ns/1ps
`default_nettype none
module mmbr_cmd_decode (
  input wire logic [7:0] cmd_code,
  output logic [1:0] cmd_kind,
  output logic [7:0] blk_base,
  output logic [5:0] blk_len,
  output logic cmd_reserved
);
  logic [3:0] idx;
  logic is_fixed;
  assign idx = 4'(cmd_code - mmbr_pkg::CMD_FIXED_FIRST);
  assign is_fixed = (cmd_code >= mmbr_pkg::CMD_FIXED_FIRST) && (cmd_code <= mmbr_pkg::CMD_FIXED_LAST);
  assign cmd_reserved = cmd_code >= mmbr_pkg::CMD_RESERVED_FIRST;
  assign cmd_kind = (cmd_code == mmbr_pkg::CMD_BLOCK_WRITE) ? mmbr_pkg::MMBR_CMD_BWRITE :
                    (cmd_code == mmbr_pkg::CMD_BLOCK_CALL) ? mmbr_pkg::MMBR_CMD_BCALL :
                    is_fixed ? mmbr_pkg::MMBR_CMD_FIXED : mmbr_pkg::MMBR_CMD_REG;
  always_comb begin
    blk_base = 8'h00;
    blk_len = 6'h00;
    if (is_fixed) begin
      unique case (idx)
        4'h0: begin blk_base = 8'h40; blk_len = 6'h08; end
        4'h1: begin blk_base = 8'h48; blk_len = 6'h08; end
        4'h2: begin blk_base = 8'h50; blk_len = 6'h06; end
        4'h3: begin blk_base = 8'h56; blk_len = 6'h10; end
        4'h4: begin blk_base = 8'h67; blk_len = 6'h04; end
        4'h5: begin blk_base = 8'h6E; blk_len = 6'h08; end
        4'h6: begin blk_base = 8'h78; blk_len = 6'h0C; end
        4'h7: begin blk_base = 8'h90; blk_len = 6'h20; end
        4'h8: begin blk_base = 8'hB4; blk_len = 6'h08; end
        4'h9: begin blk_base = 8'hC8; blk_len = 6'h08; end
        4'hA: begin blk_base = 8'hD0; blk_len = 6'h10; end
        4'hB: begin blk_base = 8'hE5; blk_len = 6'h09; end
        default: begin blk_base = 8'h00; blk_len = 6'h00; end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verif/mmbr_host_model.sv
// Host side model: byte register cycles and command code classification requests
`timescale 1ns/1ps
`default_nettype none
module mmbr_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [7:0] cmd_code,
  output logic cmd_valid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    cmd_code = 8'h00;
    cmd_valid = 1'b0;
  end
  // Released data lines show the inverse so a stale value cannot pass as fresh
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    h = reg_hit;
  endtask
  // Codes FEh and FFh are only sent when a scenario probes the reserved flag
  task automatic cmd(input logic [7:0] c);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~c;
  endtask
endmodule
`default_nettype wire

// ===== verif/monitor_mask_block_cmd_test_regs_test.sv
// Self-checking bench for the mask, offset, test and command decode register bank
`timescale 1ns/1ps
`default_nettype none
module monitor_mask_block_cmd_test_regs_test;
  logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr, reg_rd, cmd_valid, reg_hit, cmd_reserved_r, temp_valid = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cmd_code, cmd_base_r, input_err_r, d, zone1a_temp_r, zone2a_temp_r;
  logic [7:0] input_err_raw = 8'h00, zone1a_raw = 8'h00, zone2a_raw = 8'h00, regv [0:255];
  logic [5:0] cmd_len_r, misc_err_r, misc_err_raw = 6'h00;
  logic [3:0] fan_err_r, fan_err_raw = 4'h0;
  logic [2:0] tv_err_r, tv_err_raw = 3'h0;
  logic [1:0] cmd_kind_r;
  logic xm, c1a, c1b, c2a, c2b, h;
  logic [31:0] rs = 32'h9;
  int mismatches = 0, n_checks = 0;
  localparam logic [7:0] ADDRS [15] = '{8'h00, 8'h01, 8'h05, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA,
    8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF};
  localparam logic [7:0] RSTS [15] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h07, 8'hFF,
    8'h07, 8'hFF, 8'h3F, 8'h00, 8'h00};
  localparam logic [7:0] FB_BASE [12] = '{8'h40, 8'h48, 8'h50, 8'h56, 8'h67, 8'h6E, 8'h78, 8'h90, 8'hB4, 8'hC8,
    8'hD0, 8'hE5};
  localparam logic [5:0] FB_LEN [12] = '{6'h08, 6'h08, 6'h06, 6'h10, 6'h04, 6'h08, 6'h0C, 6'h20, 6'h08, 6'h08,
    6'h10, 6'h09};
  localparam logic [7:0] SLEEPS [5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h02};
  always #4 sys_clk = ~sys_clk;
  mmbr_regs i_mmbr_regs (.sys_clk(sys_clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .cmd_code(cmd_code),
    .cmd_valid(cmd_valid), .cmd_kind_r(cmd_kind_r), .cmd_base_r(cmd_base_r), .cmd_len_r(cmd_len_r),
    .cmd_reserved_r(cmd_reserved_r), .input_err_raw(input_err_raw), .fan_err_raw(fan_err_raw),
    .tv_err_raw(tv_err_raw), .misc_err_raw(misc_err_raw), .input_err_r(input_err_r), .fan_err_r(fan_err_r),
    .tv_err_r(tv_err_r), .misc_err_r(misc_err_r), .zone1a_raw(zone1a_raw), .zone2a_raw(zone2a_raw),
    .temp_valid(temp_valid), .zone1a_temp_r(zone1a_temp_r), .zone2a_temp_r(zone2a_temp_r),
    .xor_tree_mode_on(xm), .cpu1_diode_a_transistor_on(c1a), .cpu1_diode_b_transistor_on(c1b),
    .cpu2_diode_a_transistor_on(c2a), .cpu2_diode_b_transistor_on(c2b));
  mmbr_host_model i_mmbr_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_code(cmd_code),
    .cmd_valid(cmd_valid));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] wmask(input logic [7:0] a);
    return (a == 8'h00) ? 8'h01 : (a == 8'h05) ? 8'h0F : 8'hFF;
  endfunction
  // Expected masked errors packed as misc, temp/volt, fan, input
  function automatic logic [20:0] exp_err(input logic [7:0] s, input logic [20:0] raw);
    logic [7:0] mi;
    logic [3:0] mf;
    logic [2:0] mt;
    mi = regv[8'hEC] | ((s == 8'h01) ? regv[8'hE5] : (s == 8'h03) ? regv[8'hE7] : (s == 8'h04) ? regv[8'hEA] : 8'h00);
    mf = (s == 8'h01) ? regv[8'hE6][3:0] : (s == 8'h03) ? regv[8'hE8][3:0] : 4'h0;
    mt = (s == 8'h03) ? regv[8'hE9][2:0] : (s == 8'h04) ? regv[8'hEB][2:0] : 3'h0;
    return raw & ~{regv[8'hED][5:0], mt, mf, mi};
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A full run takes well under two thousand cycles; this limit leaves ample margin
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
  initial begin
    logic [20:0] raw, e;
    logic [7:0] c, v;
    repeat (6) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    check("outputs_after_reset", {3'h0, xm, c1a, c1b, c2a, c2b}, 8'h00);
    foreach (ADDRS[i]) begin
      regv[ADDRS[i]] = RSTS[i];
      i_mmbr_host_model.rd(ADDRS[i], d, h);
      check("reset_value", d, RSTS[i]);
      check("reset_hit", {7'h0, h}, 8'h01);
    end
    foreach (ADDRS[i]) begin
      rs = xs(rs);
      regv[ADDRS[i]] = rs[7:0] & wmask(ADDRS[i]);
      i_mmbr_host_model.wr(ADDRS[i], rs[7:0]);
      i_mmbr_host_model.rd(ADDRS[i], d, h);
      check("readback", d, regv[ADDRS[i]]);
    end
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 8'hFF : 8'h00;
      i_mmbr_host_model.wr(8'h00, v);
      i_mmbr_host_model.wr(8'h05, v);
      i_mmbr_host_model.rd(8'h05, d, h);
      check("diode_mode_read", d, v & 8'h0F);
      check("mode_outputs", {3'h0, xm, c2b, c2a, c1b, c1a}, v & 8'h1F);
    end
    regv[8'h00] = 8'h00;
    regv[8'h05] = 8'h00;
    i_mmbr_host_model.wr(8'h02, 8'hA5);
    i_mmbr_host_model.rd(8'h02, d, h);
    check("unmapped_data", d, 8'h00);
    check("unmapped_hit", {7'h0, h}, 8'h00);
    rs = xs(rs);
    i_mmbr_host_model.wr(8'h01, rs[7:0]);
    i_mmbr_host_model.rd(8'hE5, d, h);
    check("scratch_isolation", d, regv[8'hE5]);
    for (int i = 0; i < 17; i++) begin
      c = (i == 16) ? 8'h40 : 8'hF0 + i[7:0];
      i_mmbr_host_model.cmd(c);
      v = (c == 8'hF0) ? 8'h01 : (c == 8'hF1) ? 8'h02 : (c >= 8'hF2 && c <= 8'hFD) ? 8'h03 : 8'h00;
      check("cmd_kind", {6'h0, cmd_kind_r}, v);
      check("cmd_base", cmd_base_r, (v == 8'h03) ? FB_BASE[i - 2] : 8'h00);
      check("cmd_len", {2'h0, cmd_len_r}, (v == 8'h03) ? {2'h0, FB_LEN[i - 2]} : 8'h00);
      check("cmd_reserved", {7'h0, cmd_reserved_r}, {7'h0, c >= 8'hFE});
    end
    repeat (4) begin
      rs = xs(rs);
      @(posedge sys_clk);
      #1;
      temp_valid = 1'b1;
      zone1a_raw = rs[7:0];
      zone2a_raw = rs[15:8];
      @(posedge sys_clk);
      #1;
      temp_valid = 1'b0;
      check("zone1a_sum", zone1a_temp_r, rs[7:0] + regv[8'hEE]);
      check("zone2a_sum", zone2a_temp_r, rs[15:8] + regv[8'hEF]);
    end
    for (int p = 0; p < 2; p++) begin
      foreach (SLEEPS[j]) begin
        i_mmbr_host_model.wr(8'hE4, SLEEPS[j]);
        regv[8'hE4] = SLEEPS[j];
        for (int n = 0; n < 3; n++) begin
          rs = xs(rs);
          // First sample raises every error so each mask bit is exercised
          raw = (n == 0) ? 21'h1FFFFF : rs[20:0];
          @(posedge sys_clk);
          #1;
          {misc_err_raw, tv_err_raw, fan_err_raw, input_err_raw} = raw;
          @(posedge sys_clk);
          #1;
          e = exp_err(SLEEPS[j], raw);
          check("input_err", input_err_r, e[7:0]);
          check("fan_err", {4'h0, fan_err_r}, {4'h0, e[11:8]});
          check("tv_err", {5'h0, tv_err_r}, {5'h0, e[14:12]});
          check("misc_err", {2'h0, misc_err_r}, {2'h0, e[20:15]});
        end
      end
      // Inverting all masks lets the second pass see every mask bit in its other state
      for (int a = 8'hE5; a <= 8'hED; a++) begin
        regv[a] = ~regv[a];
        i_mmbr_host_model.wr(a[7:0], regv[a]);
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
